// ### sram_ctl_params.svh
// Timing constants and widths for the static memory host controller
`ifndef SRAM_CTL_PARAMS_SVH
`define SRAM_CTL_PARAMS_SVH
`define CLK_PERIOD_NS 20
`define ADDR_W 16
`define DATA_W 4
`define MEM_WORDS 65536
`define T_ACCESS_NS 45
`define T_CW_NS 40
`define T_AW_NS 40
`define T_DW_NS 20
`define T_WZ_NS 15
`define T_HZ_NS 20
// Least times round up to whole cycles, at least one
`define CYC_UP(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define ACCESS_CYC `CYC_UP(`T_ACCESS_NS)
`define WRITE_CYC `CYC_UP(`T_CW_NS)
`define WZ_CYC `CYC_UP(`T_WZ_NS)
`define HZ_CYC `CYC_UP(`T_HZ_NS)
`define RECOVER_CYC `CYC_UP(`T_ACCESS_NS)
`endif

// ### sram_ctl_pkg.sv
// Types for the static memory host controller
package sram_ctl_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_READ = 6'h02,
        ST_WOFF = 6'h04,
        ST_WRITE = 6'h08,
        ST_GAP = 6'h10,
        ST_RET = 6'h20
    } ctl_state_t;
    typedef struct packed {
        logic [15:0] word_address;
        logic cs_n;
        logic we_n;
        logic [3:0] dout;
        logic doe;
    } pins_t;
    typedef struct packed {
        ctl_state_t state;
        pins_t pins;
        logic [7:0] cnt;
        logic [3:0] rdata;
        logic done;
        logic in_ret;
    } ctl_st_t;
endpackage : sram_ctl_pkg

// ### sram_host_ctl.sv
// Host controller driving an asynchronous 64k x 4 static memory
`timescale 1ns/100ps
`include "sram_ctl_params.svh"
// Behaviour
// - Memory holds 65536 four-bit words, sixteen address lines, four data lines.
// - Write strobe stays high throughout every read cycle.
// - Reads may keep select low and change only the address.
// - Address is valid before or as select falls for select-led reads.
// - Select is low at least the select-to-end-of-write time.
// - Address stands stable at least the address-to-end-of-write time.
// - Write data is valid the setup time before write end, held through it.
// - Device is deselected no later than supply starts falling for retention.
// - After supply returns, wait one read cycle time before any access.
module sram_host_ctl
    import sram_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [`ADDR_W-1:0] req_addr,
    input wire logic [`DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic [`DATA_W-1:0] rsp_rdata,
    output logic rsp_done,
    input wire logic retain_req,
    output logic retain_ok,
    output logic [`ADDR_W-1:0] word_address,
    output logic cs_n,
    output logic we_n,
    output logic [`DATA_W-1:0] shared_data_lines_o,
    output logic shared_data_lines_oe,
    input wire logic [`DATA_W-1:0] shared_data_lines_i
);
    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ACC_C = 8'(`ACCESS_CYC);
    localparam logic [7:0] WR_C = 8'(`WRITE_CYC);
    localparam logic [7:0] WZ_C = 8'(`WZ_CYC);
    localparam logic [7:0] HZ_C = 8'(`HZ_CYC);
    localparam logic [7:0] REC_C = 8'(`RECOVER_CYC);

    ctl_st_t st_ff;
    ctl_st_t nxt_st;
    logic [`DATA_W-1:0] din_s1_ff;
    logic [`DATA_W-1:0] din_s2_ff;
    logic ret_s1_ff;
    logic ret_s2_ff;

    // Pin inputs pass two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            din_s1_ff <= 4'h0;
            din_s2_ff <= 4'h0;
            ret_s1_ff <= 1'b0;
            ret_s2_ff <= 1'b0;
        end else begin
            din_s1_ff <= shared_data_lines_i;
            din_s2_ff <= din_s1_ff;
            ret_s1_ff <= retain_req;
            ret_s2_ff <= ret_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        case (st_ff.state)
            ST_IDLE: begin
                nxt_st.pins.cs_n = 1'b1;
                nxt_st.pins.we_n = 1'b1;
                nxt_st.pins.doe = 1'b0;
                if (ret_s2_ff) begin
                    nxt_st.state = ST_RET;
                    nxt_st.in_ret = 1'b1;
                    // Fresh recovery count even for a one-cycle retention pulse
                    nxt_st.cnt = REC_C;
                end else if (req_valid) begin
                    // Address and select change together
                    nxt_st.pins.word_address = req_addr;
                    nxt_st.pins.cs_n = 1'b0;
                    nxt_st.pins.dout = req_wdata;
                    if (req_write) begin
                        nxt_st.pins.we_n = 1'b0;
                        nxt_st.cnt = WZ_C;
                        nxt_st.state = ST_WOFF;
                    end else begin
                        nxt_st.cnt = ACC_C + 8'h2;
                        nxt_st.state = ST_READ;
                    end
                end
            end
            ST_READ: begin
                // Strobe held high; two extra cycles cover the input sync
                // Select dropped per read; address-only reads not used
                nxt_st.cnt = st_ff.cnt - 8'h1;
                if (st_ff.cnt == 8'h1) begin
                    nxt_st.rdata = din_s2_ff;
                    nxt_st.done = 1'b1;
                    nxt_st.pins.cs_n = 1'b1;
                    nxt_st.cnt = HZ_C;
                    nxt_st.state = ST_GAP;
                end
            end
            ST_WOFF: begin
                nxt_st.cnt = st_ff.cnt - 8'h1;
                if (st_ff.cnt == 8'h1) begin
                    nxt_st.pins.doe = 1'b1;
                    nxt_st.cnt = WR_C;
                    nxt_st.state = ST_WRITE;
                end
            end
            ST_WRITE: begin
                nxt_st.cnt = st_ff.cnt - 8'h1;
                if (st_ff.cnt == 8'h1) begin
                    // Strobe and select rise together, data still driven
                    nxt_st.pins.we_n = 1'b1;
                    nxt_st.pins.cs_n = 1'b1;
                    nxt_st.done = 1'b1;
                    nxt_st.cnt = 8'h1;
                    nxt_st.state = ST_GAP;
                end
            end
            ST_GAP: begin
                nxt_st.pins.doe = 1'b0;
                nxt_st.cnt = st_ff.cnt - 8'h1;
                if (st_ff.cnt == 8'h1)
                    nxt_st.state = ST_IDLE;
            end
            ST_RET: begin
                nxt_st.pins.cs_n = 1'b1;
                nxt_st.pins.we_n = 1'b1;
                nxt_st.pins.doe = 1'b0;
                if (ret_s2_ff) begin
                    nxt_st.cnt = REC_C;
                end else begin
                    // Full recovery count runs after retain_ok drops
                    nxt_st.in_ret = 1'b0;
                    if (st_ff.cnt == 8'h0)
                        nxt_st.state = ST_IDLE;
                    else
                        nxt_st.cnt = st_ff.cnt - 8'h1;
                end
            end
            default: nxt_st.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff.state <= ST_IDLE;
            st_ff.pins <= '{word_address: 16'h0000, cs_n: 1'b1, we_n: 1'b1,
                dout: 4'h0, doe: 1'b0};
            st_ff.cnt <= 8'h00;
            st_ff.rdata <= 4'h0;
            st_ff.done <= 1'b0;
            st_ff.in_ret <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign req_ready = (st_ff.state == ST_IDLE) && !ret_s2_ff;
    assign rsp_rdata = st_ff.rdata;
    assign rsp_done = st_ff.done;
    assign retain_ok = st_ff.in_ret;
    assign word_address = st_ff.pins.word_address;
    assign cs_n = st_ff.pins.cs_n;
    assign we_n = st_ff.pins.we_n;
    assign shared_data_lines_o = st_ff.pins.dout;
    assign shared_data_lines_oe = st_ff.pins.doe;

    ////////////////////////////////////////////////////////////////////////
    drive_read_a: assert property (@(posedge clk) disable iff (rst)
        !(shared_data_lines_oe && we_n && !cs_n))
        else $error("data lines driven during a read");
    read_strobe_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.state == ST_READ) |-> we_n)
        else $error("strobe low in read");
    write_off_a: assert property (@(posedge clk) disable iff (rst)
        $fell(we_n) |-> !shared_data_lines_oe [*1] ##1 shared_data_lines_oe)
        else $error("data driven before device output off");
    write_len_a: assert property (@(posedge clk) disable iff (rst)
        $rose(shared_data_lines_oe) |-> (!cs_n && !we_n) [*2] ##1 (cs_n && we_n))
        else $error("write pulse length wrong");
    addr_hold_a: assert property (@(posedge clk) disable iff (rst)
        (!cs_n && $past(!cs_n)) |-> $stable(word_address))
        else $error("address moved while selected");
    data_hold_a: assert property (@(posedge clk) disable iff (rst)
        $rose(we_n) && $past(shared_data_lines_oe) |-> shared_data_lines_oe)
        else $error("write data removed before write end");
    read_len_a: assert property (@(posedge clk) disable iff (rst)
        $fell(cs_n) && we_n |-> !cs_n [*5] ##1 cs_n ##0 rsp_done)
        else $error("read cycle length wrong");
    ret_desel_a: assert property (@(posedge clk) disable iff (rst)
        retain_ok |-> cs_n && !shared_data_lines_oe)
        else $error("selected during retention");
    ret_recover_a: assert property (@(posedge clk) disable iff (rst)
        $fell(retain_ok) |-> !req_ready [*3])
        else $error("access too soon after retention");
endmodule : sram_host_ctl

// ### sram_model.sv
// Behavioural 64k x 4 static memory seen from its pins
`timescale 1ns/100ps
`include "sram_ctl_params.svh"
module sram_model
    import sram_ctl_pkg::*;
(
    input wire logic [`ADDR_W-1:0] word_address,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic host_oe,
    input wire logic [`DATA_W-1:0] bus_in,
    output logic [`DATA_W-1:0] bus_out,
    output logic fault
);
    logic [`DATA_W-1:0] mem [0:`MEM_WORDS-1];
    logic [`DATA_W-1:0] last_ff = 4'h0;
    logic wr_on = 1'b0;
    realtime t_chg = 0;
    realtime t_din = 0;
    initial fault = 1'b0;
    always @(bus_in) t_din = $realtime;
    ////////////////////////////////////////////////////////////////
    always @(word_address or cs_n or we_n) begin
        t_chg = $realtime;
        if (!cs_n && !we_n) begin
            wr_on = 1'b1;
        end else if (wr_on) begin
            wr_on = 1'b0;
            // Short data setup corrupts the word
            if ($realtime - t_din >= `T_DW_NS) mem[word_address] = bus_in;
            else mem[word_address] = ~bus_in;
        end
    end
    ////////////////////////////////////////////////////////////////
    always begin
        #1;
        if (!cs_n && we_n && $realtime - t_chg >= `T_ACCESS_NS) begin
            bus_out = mem[word_address];
            last_ff = bus_out;
        end else begin
            bus_out = ~last_ff;
        end
        if (!cs_n && we_n && host_oe) fault = 1'b1;
        // Host may only drive once the outputs have had time to turn off
        if (!cs_n && !we_n && host_oe && $realtime - t_chg < `T_WZ_NS) fault = 1'b1;
    end
endmodule : sram_model

// ### tb_top.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/100ps
`include "sram_ctl_params.svh"
module tb_top;
    import sram_ctl_pkg::*;
    logic clk, rst, req_valid, req_write, retain_req, req_ready, rsp_done, retain_ok;
    logic cs_n, we_n, lines_oe, fault;
    logic [15:0] req_addr, word_address;
    logic [3:0] req_wdata, rsp_rdata, lines_o, lines, m_out;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    assign lines = lines_oe ? lines_o : m_out;
    sram_host_ctl dut (.clk(clk), .rst(rst), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_rdata(rsp_rdata), .rsp_done(rsp_done), .retain_req(retain_req),
        .retain_ok(retain_ok), .word_address(word_address), .cs_n(cs_n), .we_n(we_n),
        .shared_data_lines_o(lines_o), .shared_data_lines_oe(lines_oe),
        .shared_data_lines_i(lines));
    sram_model mem_m (.word_address(word_address), .cs_n(cs_n), .we_n(we_n),
        .host_oe(lines_oe), .bus_in(lines), .bus_out(m_out), .fault(fault));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic do_op(input logic wr, input logic [15:0] a, input logic [3:0] d);
        int n;
        int lo;
        n = 0;
        lo = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        #1;
        check("ready while busy", 16'h0, req_ready);
        do begin
            @(posedge clk);
            #1;
            n++;
            if (cs_n === 1'b0) lo++;
            if (!wr) check("strobe in read", 16'h1, we_n);
        end while (rsp_done !== 1'b1 && n < 20);
        check("done pulse", 16'h1, rsp_done);
        if (wr) check("select low time", 16'h1, lo >= `WRITE_CYC);
        else check("read data", d, rsp_rdata);
        if (!wr) check("access time", 16'h1, lo * `CLK_PERIOD_NS >= `T_ACCESS_NS);
        check("no contention", 16'h0, fault);
    endtask : do_op
    task automatic scen_edges();
        do_op(1'b1, 16'h0000, 4'h5);
        do_op(1'b1, 16'hffff, 4'ha);
        do_op(1'b0, 16'h0000, 4'h5);
        do_op(1'b0, 16'hffff, 4'ha);
    endtask : scen_edges
    task automatic scen_overwrite();
        do_op(1'b1, 16'h1234, 4'hf);
        do_op(1'b0, 16'h1234, 4'hf);
        do_op(1'b1, 16'h1234, 4'h0);
        do_op(1'b0, 16'h1234, 4'h0);
        do_op(1'b0, 16'h0000, 4'h5);
    endtask : scen_overwrite
    task automatic scen_retain();
        int n;
        n = 0;
        @(posedge clk);
        retain_req <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (retain_ok !== 1'b1 && n < 20);
        #1;
        check("retention entered", 16'h1, retain_ok);
        check("deselected", 16'h1, cs_n);
        check("refused", 16'h0, req_ready);
        @(posedge clk);
        retain_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (req_ready !== 1'b1 && n < 20);
        check("recovery wait", 16'h1, n * `CLK_PERIOD_NS >= `T_ACCESS_NS);
        do_op(1'b0, 16'hffff, 4'ha);
    endtask : scen_retain
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 16'h0;
        req_wdata = 4'h0;
        retain_req = 1'b0;
        repeat (8) @(posedge clk);
        check("select in reset", 16'h1, cs_n);
        check("drive in reset", 16'h0, lines_oe);
        rst <= 1'b0;
        scen_edges();
        scen_overwrite();
        scen_retain();
        finish_test();
    end
endmodule : tb_top
